// File: hdl/fp_format_and_register_banks.sv
// Contract
// RQ1: exponent biased by 127 or 1023
// RQ2: sign, exponent, fraction; 8/23 or 11/52
// RQ3: lowest code zero/denormal, highest inf/NaN
// RQ4: normal 1.f, denormal 0.f at Emin
// RQ5: all-ones exponent: NaN or infinity
// RQ6: fraction msb set means signalling NaN
// RQ7: untrapped signalling NaN yields quiet NaN
// RQ8: trapped signalling NaN: exception, no write
// RQ9: quiet NaN passes silently
// RQ10: created quiet NaN uses fixed pattern
// RQ11: denormal is zero exponent, nonzero fraction
// RQ12: flush on: denormals become zero
// RQ13: flush off: denormals kept as is
// RQ14: thirty-two physical words, two banks
// RQ15: single names follow bank swap
// RQ16: extended names use opposite bank
// RQ17: double joins even and odd single
// RQ18: vector joins four consecutive singles
// RQ19: extended double joins extended pair
// RQ20: invalid sets cause and sticky flag; code sets them only when trapped (en_v set)
// RQ21: status/control resets to 0x00040001
// RQ22: copy, abs, negate touch sign only
`timescale 1ns/1ps
`default_nettype none
module fp_format_and_register_banks (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [fp_pkg::SP_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [fp_pkg::SP_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic invalid_exc,
    output logic register_bank_swap,
    output logic denormal_flush
);
    import fp_pkg::*;

    // *****************************************************************
    // helpers
    // *****************************************************************
    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (nw & m);
    endfunction : merge

    function automatic logic [4:0] map_idx(input logic fr, input logic ext,
            input logic [3:0] idx);
        return {fr ^ ext, idx}; // [RQ15] [RQ16]
    endfunction : map_idx

    function automatic fp_class_e classify(input logic dbl,
            input logic [63:0] v);
        logic e1;
        logic e0;
        logic fz;
        logic fm;
        e1 = dbl ? &v[DP_EXP_MSB:DP_EXP_LSB] : &v[SP_EXP_MSB:SP_EXP_LSB];
        e0 = dbl ? ~|v[DP_EXP_MSB:DP_EXP_LSB] : ~|v[SP_EXP_MSB:SP_EXP_LSB];
        fz = dbl ? ~|v[DP_FRAC_MSB:0] : ~|v[SP_FRAC_MSB:0]; // [RQ2]
        fm = dbl ? v[DP_FRAC_MSB] : v[SP_FRAC_MSB];
        if (e1 && !fz) begin
            return fm ? CL_SNAN : CL_QNAN; // [RQ5] [RQ6]
        end else if (e1) begin
            return CL_INF; // [RQ3] [RQ5]
        end else if (e0 && fz) begin
            return CL_ZERO; // [RQ4]
        end else if (e0) begin
            return CL_DENORM; // [RQ11]
        end
        return CL_NORMAL;
    endfunction : classify

    // effective exponent: denormals sit at Emin with a 0.f significand
    function automatic logic [11:0] unbias(input logic dbl,
            input logic [63:0] v);
        logic [11:0] e;
        e = dbl ? {1'b0, v[DP_EXP_MSB:DP_EXP_LSB]}
                : {4'h0, v[SP_EXP_MSB:SP_EXP_LSB]};
        if (e == 12'h000) begin
            return dbl ? 12'(DP_EMIN) : 12'(SP_EMIN); // [RQ3] [RQ4]
        end
        return e - (dbl ? 12'(DP_BIAS) : 12'(SP_BIAS)); // [RQ1]
    endfunction : unbias

    // *****************************************************************
    // state
    // *****************************************************************
    logic wait_ff;
    logic [31:0] rdata_ff;
    logic [31:0] stat_ff;
    logic [31:0] nxt_stat;
    logic [31:0] cmd_ff;
    logic [63:0] result_ff;
    logic [31:0] class_ff;
    logic [4:0] pidx_ff;
    logic [6:0] vsel_ff;
    logic exc_ff;
    logic [31:0] phys_ff [32]; // [RQ14]

    // *****************************************************************
    // bus decode
    // *****************************************************************
    wire logic req = avs_read | avs_write;
    wire logic acc = req & ~wait_ff;
    wire logic wr = acc & avs_write;
    wire logic [5:0] wa = avs_address[7:2];
    wire logic sel_stat = wa == OFF_STAT[7:2];
    wire logic sel_cmd = wa == OFF_CMD[7:2];
    wire logic sel_rlo = wa == OFF_RLO[7:2];
    wire logic sel_rhi = wa == OFF_RHI[7:2];
    wire logic sel_cls = wa == OFF_CLASS[7:2];
    wire logic sel_pidx = wa == OFF_PIDX[7:2];
    wire logic sel_pdata = wa == OFF_PDATA[7:2];
    wire logic sel_vsel = wa == OFF_VSEL[7:2];
    wire logic sel_view = wa[5:2] == OFF_VIEW0[7:4];
    wire logic [31:0] cmd_wd = merge(cmd_ff, avs_writedata, avs_byteenable);

    // *****************************************************************
    // operand fetch through the views
    // *****************************************************************
    wire logic fr = stat_ff[STAT_FR];
    wire logic dn = stat_ff[STAT_DN];
    wire logic en_v = stat_ff[EN_V];
    wire logic ex = wr & sel_cmd;
    wire logic dbl = cmd_wd[CMD_DBL];
    wire logic xs = cmd_wd[CMD_XSRC];
    wire logic xd = cmd_wd[CMD_XDST];
    wire fp_op_e op = fp_op_e'(cmd_wd[1:0]);
    wire logic is_val = op == OP_VALUE;
    // double names force an even first word, odd word follows
    wire logic [3:0] ia = {cmd_wd[CMD_SRCA_LSB+3:CMD_SRCA_LSB+1],
                           cmd_wd[CMD_SRCA_LSB] & ~dbl};
    wire logic [3:0] ib = {cmd_wd[CMD_SRCB_LSB+3:CMD_SRCB_LSB+1],
                           cmd_wd[CMD_SRCB_LSB] & ~dbl};
    wire logic [3:0] id = {cmd_wd[CMD_DST_LSB+3:CMD_DST_LSB+1],
                           cmd_wd[CMD_DST_LSB] & ~dbl};
    wire logic [4:0] pa0 = map_idx(fr, xs, ia);
    wire logic [4:0] pa1 = map_idx(fr, xs, {ia[3:1], 1'b1});
    wire logic [4:0] pb0 = map_idx(fr, xs, ib);
    wire logic [4:0] pb1 = map_idx(fr, xs, {ib[3:1], 1'b1});
    wire logic [4:0] pd0 = map_idx(fr, xd, id);
    wire logic [4:0] pd1 = map_idx(fr, xd, {id[3:1], 1'b1});
    wire logic [63:0] opa = dbl ? {phys_ff[pa0], phys_ff[pa1]} // [RQ17] [RQ19]
                                : {32'h0, phys_ff[pa0]};
    wire logic [63:0] opb = dbl ? {phys_ff[pb0], phys_ff[pb1]}
                                : {32'h0, phys_ff[pb0]};

    // *****************************************************************
    // operation
    // *****************************************************************
    wire fp_class_e ca = classify(dbl, opa);
    wire fp_class_e cb = classify(dbl, opb);
    wire logic sn = (ca == CL_SNAN) | (cb == CL_SNAN);
    wire logic qn = (ca == CL_QNAN) | (cb == CL_QNAN);
    wire logic trap = is_val & sn & en_v;
    wire logic sa = dbl ? opa[DP_SIGN] : opa[SP_SIGN];
    wire logic ns = (op == OP_ABS) ? 1'b0 : (op == OP_NEG) ? ~sa : sa;
    wire logic [63:0] sign_res = dbl ? {ns, opa[DP_SIGN-1:0]} // [RQ22]
                                     : {32'h0, ns, opa[SP_SIGN-1:0]};
    wire logic [63:0] qnan_res = dbl ? DP_QNAN : {32'h0, SP_QNAN}; // [RQ10]
    wire logic [63:0] zero_res = dbl ? {sa, 63'h0} : {32'h0, sa, 31'h0};
    // the result equals source a here, so one check covers both cases
    wire logic flush = dn & (ca == CL_DENORM); // [RQ12] [RQ13]
    wire logic [63:0] val_res = (sn | qn) ? qnan_res // [RQ7] [RQ9]
                              : flush ? zero_res : opa;
    wire logic [63:0] res = is_val ? val_res : sign_res;
    wire logic we = ex & ~trap; // [RQ8]
    wire logic hid = ca == CL_NORMAL; // [RQ4]
    wire logic [63:0] keep_mask = dbl ? 64'h7FFFFFFF_FFFFFFFF
                                      : 64'hFFFFFFFF_7FFFFFFF;

    // *****************************************************************
    // status/control
    // *****************************************************************
    always_comb begin
        nxt_stat = stat_ff;
        if (wr & sel_stat) begin
            nxt_stat = merge(stat_ff, avs_writedata, avs_byteenable)
                       & STAT_WMASK;
        end
        if (ex & is_val) begin
            nxt_stat[CAUSE_MSB:CAUSE_LSB] = 6'h00;
        end
        if (ex & trap) begin
            nxt_stat[CAUSE_V] = 1'b1; // [RQ20]
            nxt_stat[FLAG_V] = 1'b1; // [RQ20]
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stat_ff <= STAT_RESET; // [RQ21]
            exc_ff <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            exc_ff <= ex & trap; // [RQ8]
        end
    end

    // *****************************************************************
    // command, result, class and index registers
    // *****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmd_ff <= 32'h0;
            result_ff <= 64'h0;
            class_ff <= 32'h0;
            pidx_ff <= 5'h00;
            vsel_ff <= 7'h00;
        end else begin
            if (ex) begin
                cmd_ff <= cmd_wd;
                class_ff <= {4'h0, unbias(dbl, opa), 9'h0, hid, cb, ca};
            end
            if (we) begin
                result_ff <= res;
            end
            if (wr & sel_pidx) begin
                pidx_ff <= avs_writedata[4:0];
            end
            if (wr & sel_vsel) begin
                vsel_ff <= avs_writedata[6:0];
            end
        end
    end

    // *****************************************************************
    // physical register file
    // *****************************************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                phys_ff[i] <= 32'h0;
            end
        end else if (we & dbl) begin
            phys_ff[pd0] <= res[63:32]; // [RQ17] [RQ19]
            phys_ff[pd1] <= res[31:0];
        end else if (we) begin
            phys_ff[pd0] <= res[31:0];
        end else if (wr & sel_pdata) begin
            phys_ff[pidx_ff] <= merge(phys_ff[pidx_ff], avs_writedata,
                                      avs_byteenable);
        end
    end

    // *****************************************************************
    // view readback
    // *****************************************************************
    wire view_mode_e vmode =
        view_mode_e'(vsel_ff[VSEL_MODE_LSB+1:VSEL_MODE_LSB]);
    wire logic [3:0] vi = vsel_ff[3:0];
    wire logic [3:0] vbase = (vmode == VM_VECTOR) ? {vi[3:2], 2'b00} // [RQ18]
                           : (vmode == VM_DOUBLE) ? {vi[3:1], 1'b0} : vi;
    wire logic [2:0] vcnt = (vmode == VM_VECTOR) ? 3'h4
                          : (vmode == VM_DOUBLE) ? 3'h2 : 3'h1;
    logic [31:0] view_w [4];
    for (genvar k = 0; k < 4; k++) begin : g_view
        assign view_w[k] = (3'(k) < vcnt)
            ? phys_ff[map_idx(fr, vsel_ff[VSEL_EXT], vbase | 4'(k))]
            : 32'h0;
    end

    // *****************************************************************
    // bus answer
    // *****************************************************************
    // unmapped words read zero and swallow writes
    wire logic [31:0] rd_mux = sel_stat ? stat_ff
                             : sel_cmd ? cmd_ff
                             : sel_rlo ? result_ff[31:0]
                             : sel_rhi ? result_ff[63:32]
                             : sel_cls ? class_ff
                             : sel_pidx ? {27'h0, pidx_ff}
                             : sel_pdata ? phys_ff[pidx_ff]
                             : sel_vsel ? {25'h0, vsel_ff}
                             : sel_view ? view_w[wa[1:0]]
                             : 32'h0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0;
        end else begin
            wait_ff <= ~(req & wait_ff);
            if (avs_read & wait_ff) begin
                rdata_ff <= rd_mux;
            end
        end
    end

    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign invalid_exc = exc_ff;
    assign register_bank_swap = stat_ff[STAT_FR];
    assign denormal_flush = stat_ff[STAT_DN];

    // *****************************************************************
    // checks
    // *****************************************************************
    default clocking cb_chk @(posedge mclk); endclocking
    default disable iff (rst);

    chk_reset_value: assert property ( // [RQ21]
        $fell(rst) |-> stat_ff == STAT_RESET && denormal_flush
    ) else $error("status/control reset value wrong");

    chk_trap_keep: assert property ( // [RQ8] [RQ20]
        ex && is_val && sn && en_v |-> !we ##1
            (stat_ff[CAUSE_V] && stat_ff[FLAG_V] && invalid_exc)
    ) else $error("trapped signalling NaN handled wrong");

    chk_snan_quiet: assert property ( // [RQ7] [RQ10]
        ex && is_val && sn && !en_v |=> !invalid_exc
            && result_ff == ($past(dbl) ? DP_QNAN : {32'h0, SP_QNAN})
    ) else $error("signalling NaN not quieted");

    chk_qnan_silent: assert property ( // [RQ9]
        ex && is_val && qn && !sn |=> !stat_ff[CAUSE_V] && !invalid_exc
            && result_ff == ($past(dbl) ? DP_QNAN : {32'h0, SP_QNAN})
    ) else $error("quiet NaN raised or altered");

    chk_nan_class: assert property ( // [RQ5] [RQ6]
        ex && !dbl && &opa[SP_EXP_MSB:SP_EXP_LSB] && opa[SP_FRAC_MSB] |->
            ca == CL_SNAN
    ) else $error("single signalling NaN misclassified");

    chk_denorm_class: assert property ( // [RQ11]
        ex && !dbl && opa[SP_EXP_MSB:SP_EXP_LSB] == 8'h00
            && opa[SP_FRAC_MSB:0] != 23'h000000 |-> ca == CL_DENORM
    ) else $error("single denormal misclassified");

    chk_trap_hold: assert property ( // [RQ8]
        ex && trap |=> $stable(result_ff)
    ) else $error("trapped operation wrote its result");

    chk_exc_cause: assert property ( // [RQ20]
        invalid_exc |-> stat_ff[CAUSE_V] && stat_ff[FLAG_V]
    ) else $error("exception pulse without cause and flag");

    chk_flush_zero: assert property ( // [RQ12] [RQ11]
        ex && is_val && !sn && !qn && dn && !dbl && ca == CL_DENORM |=>
            result_ff[30:0] == 31'h0 && result_ff[31] == $past(sa)
    ) else $error("denormal not flushed");

    chk_denorm_kept: assert property ( // [RQ13]
        ex && is_val && !sn && !qn && !dn |=> result_ff == $past(opa)
    ) else $error("operand changed without flush");

    chk_sign_only: assert property ( // [RQ22]
        ex && !is_val |=> ((result_ff ^ $past(opa)) & $past(keep_mask))
            == 64'h0 && !invalid_exc && $stable(stat_ff)
    ) else $error("sign op touched more than sign");

    chk_bank_map: assert property ( // [RQ15] [RQ16]
        ex |-> pa0[4] == (stat_ff[STAT_FR] ^ xs) && pd0[4] == (fr ^ xd)
    ) else $error("bank selection wrong");

    chk_wait_pulse: assert property (
        !wait_ff |=> wait_ff
    ) else $error("waitrequest low longer than one cycle");

    // idle bus keeps waitrequest high so no stray ack is seen
    chk_wait_idle: assert property (
        !req && wait_ff |=> wait_ff
    ) else $error("waitrequest dropped with no request");

    cov_trap: cover property (ex && trap);
    cov_flush: cover property (ex && is_val && flush && !sn && !qn);
    cov_swap_exec: cover property (ex && fr && dbl);
    cov_vector_read: cover property (acc && sel_view && vmode == VM_VECTOR);
endmodule : fp_format_and_register_banks
`default_nettype wire

// File: hdl/fp_pkg.sv
package fp_pkg;
    // *****************************************************************
    // operand formats
    // *****************************************************************
    localparam int SP_W = 32;
    localparam int DP_W = 64;
    localparam int SP_SIGN = 31;
    localparam int SP_EXP_MSB = 30;
    localparam int SP_EXP_LSB = 23;
    localparam int SP_FRAC_MSB = 22;
    localparam int DP_SIGN = 63;
    localparam int DP_EXP_MSB = 62;
    localparam int DP_EXP_LSB = 52;
    localparam int DP_FRAC_MSB = 51;
    localparam int SP_BIAS = 127;
    localparam int DP_BIAS = 1023;
    localparam int SP_EMIN = -126;
    localparam int DP_EMIN = -1022;
    localparam logic [31:0] SP_QNAN = 32'h7FBFFFFF;
    localparam logic [63:0] DP_QNAN = 64'h7FF7FFFF_FFFFFFFF;
    // *****************************************************************
    // register map, byte addresses
    // *****************************************************************
    localparam logic [7:0] OFF_STAT = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_RLO = 8'h08;
    localparam logic [7:0] OFF_RHI = 8'h0C;
    localparam logic [7:0] OFF_CLASS = 8'h10;
    localparam logic [7:0] OFF_PIDX = 8'h14;
    localparam logic [7:0] OFF_PDATA = 8'h18;
    localparam logic [7:0] OFF_VSEL = 8'h1C;
    localparam logic [7:0] OFF_VIEW0 = 8'h20;
    // *****************************************************************
    // status/control fields
    // *****************************************************************
    localparam int STAT_FR = 21;
    localparam int STAT_DN = 18;
    localparam int CAUSE_MSB = 17;
    localparam int CAUSE_LSB = 12;
    localparam int CAUSE_V = 16;
    localparam int EN_V = 11;
    localparam int FLAG_V = 6;
    localparam logic [31:0] STAT_RESET = 32'h00040001;
    localparam logic [31:0] STAT_WMASK = 32'h003FFFFF;
    // *****************************************************************
    // command and view-select fields
    // *****************************************************************
    localparam int CMD_DBL = 2;
    localparam int CMD_XSRC = 3;
    localparam int CMD_SRCA_LSB = 4;
    localparam int CMD_SRCB_LSB = 8;
    localparam int CMD_DST_LSB = 12;
    localparam int CMD_XDST = 16;
    localparam int VSEL_EXT = 4;
    localparam int VSEL_MODE_LSB = 5;
    typedef enum logic [1:0] {OP_COPY, OP_ABS, OP_NEG, OP_VALUE} fp_op_e;
    typedef enum logic [2:0] {
        CL_ZERO, CL_DENORM, CL_NORMAL, CL_INF, CL_QNAN, CL_SNAN
    } fp_class_e;
    typedef enum logic [1:0] {VM_SINGLE, VM_DOUBLE, VM_VECTOR} view_mode_e;
endpackage : fp_pkg

// File: dv/fp_issue_model.sv
`timescale 1ns/1ps
`default_nettype none
// *****************************************************************
// pipeline side: issues one register access at a time
// *****************************************************************
module fp_issue_model (
    input wire logic mclk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output var logic [7:0] address,
    output var logic read,
    output var logic write,
    output var logic [31:0] writedata,
    output var logic [3:0] byteenable
);
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        byteenable = 4'hF;
    end
    // request held until waitrequest is seen low at a rising edge
    task automatic access(input logic rw, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q, output bit ok);
        int n;
        ok = 1'b0;
        q = 32'h00000000;
        @(posedge mclk);
        address <= a;
        writedata <= d;
        read <= ~rw;
        write <= rw;
        for (n = 0; n < 50 && !ok; n++) begin
            @(posedge mclk);
            if (waitrequest === 1'b0) begin
                ok = 1'b1;
                q = readdata;
            end
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask : access
endmodule : fp_issue_model
`default_nettype wire

// File: dv/test_fp_format_and_register_banks.sv
`timescale 1ns/1ps
`default_nettype none
module test_fp_format_and_register_banks;
    import fp_pkg::*;
    typedef struct {
        fp_op_e op;
        logic dn;
        logic trap;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] res;
        fp_class_e cls;
        logic [11:0] ue;
    } case_s;
    // *****************************************************************
    // signals
    // *****************************************************************
    localparam logic [31:0] DST_OLD = 32'h12345678;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic invalid_exc;
    logic register_bank_swap;
    logic denormal_flush;
    int err_total = 0;
    int cmp_count = 0;
    int exc_seen = 0;
    int n0, i, e, s, m, w, k;
    logic [31:0] q;
    logic [31:0] v;
    // copy/abs/neg rows first; trapped signalling row last
    case_s tbl [12] = '{
        '{OP_COPY, 1, 0, 32'h7FC00000, 0, 32'h7FC00000, CL_SNAN, 12'h080},
        '{OP_ABS, 1, 0, 32'hFFC00000, 0, 32'h7FC00000, CL_SNAN, 12'h080},
        '{OP_NEG, 0, 0, 32'h00000001, 0, 32'h80000001, CL_DENORM, 12'hF82},
        '{OP_VALUE, 0, 0, 32'h7FC00000, 0, 32'h7FBFFFFF, CL_SNAN, 12'h080},
        '{OP_VALUE, 0, 1, 32'hFF800001, 0, 32'h7FBFFFFF, CL_QNAN, 12'h080},
        '{OP_VALUE, 1, 0, 32'h80000005, 0, 32'h80000000, CL_DENORM, 12'hF82},
        '{OP_VALUE, 0, 0, 32'h80000005, 0, 32'h80000005, CL_DENORM, 12'hF82},
        '{OP_VALUE, 1, 0, 32'h40400000, 0, 32'h40400000, CL_NORMAL, 12'h001},
        '{OP_VALUE, 1, 0, 32'h00000000, 0, 32'h00000000, CL_ZERO, 12'hF82},
        '{OP_VALUE, 1, 0, 32'hFF800000, 0, 32'hFF800000, CL_INF, 12'h080},
        '{OP_VALUE, 1, 0, 32'h3F800000, 32'h7FFFFFFF, 32'h7FBFFFFF,
            CL_NORMAL, 12'h000},
        '{OP_VALUE, 1, 1, 32'h7FC00000, 0, DST_OLD, CL_SNAN, 12'h080}
    };
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        if (invalid_exc === 1'b1) begin
            exc_seen <= exc_seen + 1;
        end
    end
    fp_issue_model issue (.mclk(mclk), .waitrequest(waitrequest),
        .readdata(readdata), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable));
    fp_format_and_register_banks DUT (.mclk(mclk), .rst(rst),
        .avs_address(address), .avs_read(read), .avs_write(write),
        .avs_writedata(writedata), .avs_byteenable(byteenable),
        .avs_readdata(readdata), .avs_waitrequest(waitrequest),
        .invalid_exc(invalid_exc), .register_bank_swap(register_bank_swap),
        .denormal_flush(denormal_flush));
    // *****************************************************************
    // tasks
    // *****************************************************************
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [63:0] seen,
            input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // a hung access counts as a mismatch and ends the run
    task automatic xfer(input logic rw, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r);
        bit ok;
        issue.access(rw, a, d, r, ok);
        if (!ok) begin
            err_total++;
            report_and_stop();
        end
    endtask : xfer
    task automatic put(input int n, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, OFF_PIDX, 32'(n), r);
        xfer(1'b1, OFF_PDATA, d, r);
    endtask : put
    task automatic get(input int n, output logic [31:0] r);
        xfer(1'b1, OFF_PIDX, 32'(n), r);
        xfer(1'b0, OFF_PDATA, 32'h00000000, r);
    endtask : get
    function automatic logic [31:0] pat(input int n);
        return 32'h3F800000 + 32'(n);
    endfunction : pat
    // *****************************************************************
    // main sequence
    // *****************************************************************
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        xfer(1'b0, OFF_STAT, 0, q);
        check("status", q, STAT_RESET);
        check("flush", denormal_flush, 1);
        check("swap", register_bank_swap, 0);
        xfer(1'b0, 8'hF0, 0, q);
        check("unmapped", q, 0);
        $display("test reset done");
        for (i = 0; i < 32; i++) begin
            put(i, pat(i));
        end
        for (i = 0; i < 32; i += 7) begin
            get(i, q);
            check("phys", q, pat(i));
        end
        for (s = 0; s < 2; s++) begin
            xfer(1'b1, OFF_STAT, STAT_RESET | 32'(s) << STAT_FR, q);
            @(negedge mclk);
            check("swap", register_bank_swap, s);
            for (e = 0; e < 2; e++) begin
                for (i = 0; i < 16; i++) begin
                    for (m = 0; m < 3; m++) begin
                        if (i % (1 << m) == 0) begin
                            v = 32'(m << VSEL_MODE_LSB | e << VSEL_EXT | i);
                            xfer(1'b1, OFF_VSEL, v, q);
                            for (w = 0; w < (1 << m); w++) begin
                                xfer(1'b0, OFF_VIEW0 + 8'(4 * w), 0, q);
                                k = (s ^ e) * 16 + i + w;
                                check("view", q, pat(k));
                                check("view", q, pat(k));
                            end
                        end
                    end
                end
            end
        end
        $display("test banks done");
        xfer(1'b1, OFF_STAT, STAT_RESET, q);
        foreach (tbl[k]) begin
            v = 32'h1 | 32'(tbl[k].dn) << STAT_DN | 32'(tbl[k].trap) << EN_V;
            xfer(1'b1, OFF_STAT, v, q);
            @(negedge mclk);
            check("flush", denormal_flush, tbl[k].dn);
            put(0, tbl[k].a);
            put(1, tbl[k].b);
            put(2, DST_OLD);
            n0 = exc_seen;
            xfer(1'b1, OFF_CMD, 32'h2100 | 32'(tbl[k].op), q);
            get(2, q);
            check("dest", q, tbl[k].res);
            check("dest", q, tbl[k].res);
            check("exc", exc_seen - n0, tbl[k].res === DST_OLD);
            xfer(1'b0, OFF_CLASS, 0, q);
            check("class", q[2:0], tbl[k].cls);
            check("exponent", q[27:16], tbl[k].ue);
        end
        xfer(1'b0, OFF_STAT, 0, q);
        v = 32'h1 | 1 << STAT_DN | 1 << EN_V | 1 << CAUSE_V | 1 << FLAG_V;
        check("status", q, v);
        $display("test operations done");
        xfer(1'b1, OFF_STAT, 32'h1 | 1 << STAT_DN, q);
        put(0, 32'h800FFFFF);
        put(1, 32'hFFFFFFFF);
        xfer(1'b1, OFF_CMD, 32'h2007, q);
        xfer(1'b0, OFF_RHI, 0, q);
        check("result hi", q, 32'h80000000);
        xfer(1'b0, OFF_RLO, 0, q);
        check("result lo", q, 32'h00000000);
        put(0, 32'h7FF80000);
        put(1, 32'h00000000);
        xfer(1'b1, OFF_CMD, 32'h2007, q);
        get(2, q);
        check("dest hi", q, DP_QNAN[63:32]);
        get(3, q);
        check("dest lo", q, DP_QNAN[31:0]);
        $display("test double done");
        xfer(1'b1, OFF_STAT, STAT_RESET | 1 << STAT_FR, q);
        xfer(1'b1, OFF_CMD, 32'h2108, q);
        get(18, q);
        check("xsrc copy", q, 32'h7FF80000);
        xfer(1'b1, OFF_CMD, 32'h14004, q);
        get(4, q);
        check("xdst hi", q, pat(16));
        get(5, q);
        check("xdst lo", q, pat(17));
        $display("test extended done");
        report_and_stop();
    end
endmodule : test_fp_format_and_register_banks
`default_nettype wire
